/* core/tdl_top.sv */
`default_nettype none
module tdl_top
  import tdl_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic t1_mode_in,
  input wire logic esf_mode_in,
  input wire logic [8:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  input wire logic rx_dl_valid_in,
  input wire logic rx_dl_bit_in,
  input wire logic rx_mf_in,
  input wire logic tx_dl_req_in,
  output logic tx_dl_bit_out,
  output logic tx_dl_ins_out,
  output logic interrupt_out_n
);
  // ==========================================================
  // Register port.
  logic [7:0] rx_code_control;
  logic [7:0] rx_interrupt_mask_seven;
  logic [7:0] tx_link_byte;
  logic [7:0] tx_control_two;
  logic [7:0] tx_interrupt_mask_two;
  logic [7:0] rx_link_byte;
  logic [5:0] rx_code_value;
  logic [2:0] st7;
  logic empty_flag;

  wire logic wr_cc = reg_wr_in && reg_addr_in == ADDR_RX_CODE_CONTROL;
  wire logic wr_st7 = reg_wr_in && reg_addr_in == ADDR_RX_LATCHED_STATUS_SEVEN;
  wire logic wr_im7 = reg_wr_in && reg_addr_in == ADDR_RX_INTERRUPT_MASK_SEVEN;
  wire logic wr_tlb = reg_wr_in && reg_addr_in == ADDR_TX_LINK_BYTE;
  wire logic wr_tc2 = reg_wr_in && reg_addr_in == ADDR_TX_CONTROL_TWO;
  wire logic wr_st2 = reg_wr_in && reg_addr_in == ADDR_TX_LATCHED_STATUS_TWO;
  wire logic wr_tm2 = reg_wr_in && reg_addr_in == ADDR_TX_INTERRUPT_MASK_TWO;

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      rx_code_control <= REG_RESET;
      rx_interrupt_mask_seven <= REG_RESET;
      tx_link_byte <= REG_RESET;
      tx_control_two <= REG_RESET;
      tx_interrupt_mask_two <= REG_RESET;
    end else begin
      if (wr_cc) rx_code_control <= reg_wdata_in;
      if (wr_im7) rx_interrupt_mask_seven <= reg_wdata_in;
      if (wr_tlb) tx_link_byte <= reg_wdata_in;
      if (wr_tc2) tx_control_two <= reg_wdata_in;
      if (wr_tm2) tx_interrupt_mask_two <= reg_wdata_in;
    end
  end

  logic [7:0] rd_mux;
  always_comb begin
    unique case (reg_addr_in)
      ADDR_RX_CODE_CONTROL: rd_mux = rx_code_control;
      ADDR_RX_LINK_BYTE: rd_mux = rx_link_byte;
      ADDR_RX_CODE_VALUE: rd_mux = {2'h0, rx_code_value};
      ADDR_RX_LATCHED_STATUS_SEVEN: rd_mux = {5'h00, st7};
      ADDR_RX_INTERRUPT_MASK_SEVEN: rd_mux = rx_interrupt_mask_seven;
      ADDR_TX_LINK_BYTE: rd_mux = tx_link_byte;
      ADDR_TX_CONTROL_TWO: rd_mux = tx_control_two;
      ADDR_TX_LATCHED_STATUS_TWO: rd_mux = {3'h0, empty_flag, 4'h0};
      ADDR_TX_INTERRUPT_MASK_TWO: rd_mux = tx_interrupt_mask_two;
      default: rd_mux = REG_RESET;
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) reg_rdata_out <= REG_RESET;
    else reg_rdata_out <= rd_mux;
  end

  // ==========================================================
  // Receive bit-oriented code detector.
  wire logic esf_on = t1_mode_in && esf_mode_in;
  wire logic d4_on = t1_mode_in && !esf_mode_in;
  logic [15:0] boc_sh;
  logic boc_chk;
  logic [5:0] cand;
  logic [3:0] reps;
  logic [7:0] gap;
  logic active;

  // Oldest bit sits at bit 0: eight ones, a zero, six code bits, a zero.
  wire logic boc_match = boc_sh[7:0] == CODE_HEAD && !boc_sh[8] && !boc_sh[15];
  wire logic [5:0] boc_code = boc_sh[14:9];
  wire logic [1:0] filt_sel = rx_code_control[CC_FILT_LO +: 2];
  wire logic [1:0] dis_sel = rx_code_control[CC_DIS_LO +: 2];
  wire logic [3:0] filt_reps = FILT_TABLE[{filt_sel, 2'h0} +: 4];
  wire logic [7:0] dis_bits = {DIS_TABLE[{dis_sel, 2'h0} +: 4], 4'h0};
  wire logic same_code = boc_code == cand;
  wire logic [3:0] next_reps = same_code ? ((reps == 4'hf) ? reps : reps + 4'h1) : 4'h1;
  // Only the step onto the threshold fires, so a lasting code sets the flag once.
  // A different code restarts its count, so a one-repetition filter reports it at once.
  wire logic detect_evt = boc_chk && boc_match && next_reps == filt_reps
                          && (reps != filt_reps || !same_code);
  wire logic [7:0] next_gap = (gap == 8'hff) ? gap : gap + 8'h01;
  wire logic clear_evt = boc_chk && !boc_match && active && next_gap == dis_bits;

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      boc_sh <= 16'h0000;
      boc_chk <= 1'b0;
    end else begin
      boc_chk <= rx_dl_valid_in && esf_on;
      if (rx_dl_valid_in && esf_on) boc_sh <= {rx_dl_bit_in, boc_sh[15:1]};
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      cand <= 6'h00;
      reps <= 4'h0;
      gap <= 8'h00;
      active <= 1'b0;
      rx_code_value <= 6'h00;
    end else if (boc_chk) begin
      if (boc_match) begin
        gap <= 8'h00;
        cand <= boc_code;
        // A code that fell away must qualify again before it is reported.
        reps <= next_reps;
        if (detect_evt) begin
          active <= 1'b1;
          rx_code_value <= boc_code;
        end
      end else begin
        gap <= next_gap;
        if (clear_evt) begin
          active <= 1'b0;
          reps <= 4'h0;
        end
      end
    end
  end

  // ==========================================================
  // Legacy receive data link byte.
  tdl_link_if lk ();
  logic [7:0] pend;
  logic pend_v;

  assign lk.rx_stb = rx_dl_valid_in && t1_mode_in;
  assign lk.rx_bit = rx_dl_bit_in;

  tdl_rx_col u_rx_col (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .lk(lk)
  );

  // In D4 a filled byte waits for the multiframe edge before it is shown.
  wire logic commit_d4 = d4_on && rx_mf_in && pend_v;
  wire logic commit_esf = esf_on && lk.rx_full;
  wire logic full_evt = commit_d4 || commit_esf;

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      rx_link_byte <= REG_RESET;
      pend <= REG_RESET;
      pend_v <= 1'b0;
    end else begin
      if (lk.rx_full && d4_on) begin
        pend <= lk.rx_byte;
        pend_v <= 1'b1;
      end else if (commit_d4) begin
        pend_v <= 1'b0;
      end
      // An unread byte is simply overwritten by the next one.
      if (commit_esf) rx_link_byte <= lk.rx_byte;
      else if (commit_d4) rx_link_byte <= pend;
    end
  end

  // ==========================================================
  // Legacy transmit data link byte.
  // The D4 source sense is inverted so a cleared bit picks the register.
  wire logic src_reg = t1_mode_in && (esf_mode_in ? tx_control_two[TC2_SRC]
                                                  : !tx_control_two[TC2_SRC]);

  assign lk.tx_req = tx_dl_req_in && src_reg;
  assign lk.tx_d4 = !esf_mode_in;
  assign lk.tx_byte = esf_mode_in ? tx_link_byte : {2'h0, tx_link_byte[5:0]};

  tdl_tx_ser u_tx_ser (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .lk(lk)
  );

  // Bits go out raw; no zero insertion is done on this path.
  assign tx_dl_bit_out = lk.tx_bit;

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) tx_dl_ins_out <= 1'b0;
    else tx_dl_ins_out <= src_reg;
  end

  // ==========================================================
  // Latched flags and interrupt. A set in the clear cycle wins.
  wire logic [2:0] set7 = {full_evt, clear_evt, detect_evt};
  wire logic [2:0] clr7 = wr_st7 ? reg_wdata_in[2:0] : 3'h0;
  wire logic [2:0] next_st7 = set7 | (st7 & ~clr7);
  wire logic clr2 = wr_st2 && reg_wdata_in[ST2_EMPTY];
  wire logic next_empty = lk.tx_last || (empty_flag && !clr2);
  // Masks are taken at their next value, so a mask write moves the pin with the flags.
  wire logic [2:0] next_im7 = wr_im7 ? reg_wdata_in[2:0] : rx_interrupt_mask_seven[2:0];
  wire logic next_tm2 = wr_tm2 ? reg_wdata_in[ST2_EMPTY] : tx_interrupt_mask_two[ST2_EMPTY];
  wire logic irq_any = |(next_st7 & next_im7)
                       || (next_empty && next_tm2);

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      st7 <= 3'h0;
      empty_flag <= 1'b0;
      interrupt_out_n <= 1'b1;
    end else begin
      st7 <= next_st7;
      empty_flag <= next_empty;
      interrupt_out_n <= !irq_any;
    end
  end

  // ==========================================================
  // Checks.
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);

  AST_CHECK_ONLY_IN_ESF: assert property (
    boc_chk |-> $past(t1_mode_in && esf_mode_in))
    else $error("Code check outside T1 extended superframe mode.");
  AST_DETECT_SETS_FLAG: assert property (
    detect_evt |=> st7[ST7_DETECT] && active)
    else $error("Detect event did not set the detect flag.");
  AST_CODE_VALUE_LATCHED: assert property (
    detect_evt |=> rx_code_value == $past(boc_code))
    else $error("Detected code not shown in code value register.");
  AST_DETECT_STAYS_CLEAR: assert property (
    !st7[ST7_DETECT] && !detect_evt |=> !st7[ST7_DETECT])
    else $error("Detect flag set without a qualified code.");
  AST_CLEAR_AFTER_GAP: assert property (
    clear_evt |-> gap + 8'h01 == dis_bits ##1 st7[ST7_CLEAR] && !active)
    else $error("Clear flag timing does not match disintegration.");
  AST_IRQ_FOLLOWS_FLAGS: assert property (
    ##1 (interrupt_out_n == !(|(st7 & rx_interrupt_mask_seven[2:0])
      || (empty_flag && tx_interrupt_mask_two[ST2_EMPTY]))))
    else $error("Interrupt output disagrees with flags and masks.");
  AST_EMPTY_AFTER_BYTE: assert property (
    lk.tx_last |=> empty_flag ##0 $past(lk.tx_req, 2))
    else $error("Empty flag not set after last bit.");
  AST_FULL_SETS_FLAG: assert property (
    commit_esf |=> st7[ST7_FULL] && rx_link_byte == $past(lk.rx_byte))
    else $error("Full byte not reported.");
  AST_D4_ONLY_AT_MF: assert property (
    d4_on && !rx_mf_in && !commit_esf |=> $stable(rx_link_byte))
    else $error("D4 receive byte changed off the multiframe edge.");

  // ==========================================================
  // Checks on flag hold and clear, the code detector, the link paths and the interrupt.
  AST_CLEAR_NEEDS_EVENT: assert property (
    !st7[ST7_CLEAR] && !clear_evt |=> !st7[ST7_CLEAR])
    else $error("Clear flag set without a disintegration event.");
  AST_FULL_NEEDS_EVENT: assert property (
    !st7[ST7_FULL] && !full_evt |=> !st7[ST7_FULL])
    else $error("Full flag set without a filled byte.");
  AST_FLAGS_HOLD_UNCLEARED: assert property (
    !wr_st7 |=> (st7 & $past(st7)) == $past(st7))
    else $error("Latched receive flag dropped without a host clear.");
  AST_DETECT_CLEARED_BY_HOST: assert property (
    wr_st7 && reg_wdata_in[ST7_DETECT] && !detect_evt |=> !st7[ST7_DETECT])
    else $error("Host clear did not clear the detect flag.");
  AST_DETECT_SET_WINS: assert property (
    wr_st7 && detect_evt |=> st7[ST7_DETECT])
    else $error("Detect event lost against a host clear.");
  AST_EMPTY_NEEDS_BYTE: assert property (
    !empty_flag && !lk.tx_last |=> !empty_flag)
    else $error("Empty flag set before a whole byte was sent.");
  AST_EMPTY_HOLDS: assert property (
    empty_flag && !wr_st2 |=> empty_flag)
    else $error("Empty flag dropped without a host clear.");
  AST_EMPTY_CLEARED_BY_HOST: assert property (
    wr_st2 && reg_wdata_in[ST2_EMPTY] && !lk.tx_last |=> !empty_flag)
    else $error("Host clear did not clear the empty flag.");

  AST_NO_CODE_EVENT_OUTSIDE_ESF: assert property (
    !esf_on |=> !detect_evt && !clear_evt)
    else $error("Code event outside T1 extended superframe mode.");
  AST_CODE_VALUE_HOLDS: assert property (
    !detect_evt |=> $stable(rx_code_value))
    else $error("Code value changed without a detection.");
  AST_ACTIVE_HOLDS_UNTIL_GAP: assert property (
    active && !clear_evt |=> active)
    else $error("Code dropped before the disintegration gap ran out.");
  AST_GAP_RESTARTS_ON_CODE: assert property (
    boc_chk && boc_match |=> gap == 8'h00)
    else $error("Absence count not restarted by a valid code.");
  AST_FILTER_CHOICES: assert property (
    filt_reps inside {4'h1, 4'h3, 4'h5, 4'h7})
    else $error("Filter selection gives an unknown repetition count.");
  AST_DISINT_CHOICES: assert property (
    dis_bits inside {8'h10, 8'h20, 8'h40, 8'h80})
    else $error("Disintegration selection gives an unknown bit count.");

  AST_INSERT_IN_ESF: assert property (
    t1_mode_in && esf_mode_in && tx_control_two[TC2_SRC] |=> tx_dl_ins_out)
    else $error("Register source not inserted in extended superframe mode.");
  AST_INSERT_IN_D4: assert property (
    t1_mode_in && !esf_mode_in && !tx_control_two[TC2_SRC] |=> tx_dl_ins_out)
    else $error("Register source not inserted in D4 mode.");
  AST_BIT_ONLY_ON_REQUEST: assert property (
    !lk.tx_req |=> $stable(tx_dl_bit_out))
    else $error("Transmit bit changed without a request from the register path.");
  AST_D4_UPPER_BITS_DROPPED: assert property (
    !esf_mode_in |-> lk.tx_byte[7:6] == 2'h0)
    else $error("Upper transmit bits reach the serializer in D4 mode.");
  AST_ESF_BYTE_HOLDS: assert property (
    esf_on && !lk.rx_full |=> $stable(rx_link_byte))
    else $error("Receive byte changed without a fill in extended superframe mode.");
  AST_D4_COMMIT_PENDING: assert property (
    commit_d4 |=> st7[ST7_FULL] && rx_link_byte == $past(pend))
    else $error("Pending D4 byte not shown at the multiframe edge.");
  AST_IRQ_HIGH_WHEN_MASKED: assert property (
    rx_interrupt_mask_seven[2:0] == 3'h0 && !tx_interrupt_mask_two[ST2_EMPTY]
      && !wr_im7 && !wr_tm2 |=> interrupt_out_n)
    else $error("Interrupt output low while every mask is off.");
endmodule
`default_nettype wire

/* core/tdl_pkg.sv */
`default_nettype none
package tdl_pkg;
  // ==========================================================
  // Register offsets.
  localparam logic [8:0] ADDR_RX_CODE_CONTROL = 9'h015;
  localparam logic [8:0] ADDR_RX_LINK_BYTE = 9'h062;
  localparam logic [8:0] ADDR_RX_CODE_VALUE = 9'h063;
  localparam logic [8:0] ADDR_RX_LATCHED_STATUS_SEVEN = 9'h096;
  localparam logic [8:0] ADDR_RX_INTERRUPT_MASK_SEVEN = 9'h0a6;
  localparam logic [8:0] ADDR_TX_LINK_BYTE = 9'h162;
  localparam logic [8:0] ADDR_TX_CONTROL_TWO = 9'h182;
  localparam logic [8:0] ADDR_TX_LATCHED_STATUS_TWO = 9'h191;
  localparam logic [8:0] ADDR_TX_INTERRUPT_MASK_TWO = 9'h1a1;
  // ==========================================================
  // Field positions.
  localparam int CC_FILT_LO = 0;
  localparam int CC_DIS_LO = 4;
  localparam int ST7_DETECT = 0;
  localparam int ST7_CLEAR = 1;
  localparam int ST7_FULL = 2;
  localparam int TC2_SRC = 7;
  localparam int ST2_EMPTY = 4;
  // ==========================================================
  // Reset values and code framing.
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] CODE_HEAD = 8'hff;
  localparam logic [2:0] LAST_BIT_ESF = 3'h7;
  localparam logic [2:0] LAST_BIT_D4 = 3'h5;
  // ==========================================================
  // Filter repetitions, and disintegration bits in sixteens, per selection code; one nibble per code value.
  localparam logic [15:0] FILT_TABLE = 16'h7531;
  localparam logic [15:0] DIS_TABLE = 16'h8421;
endpackage
`default_nettype wire

/* core/tdl_link_if.sv */
`default_nettype none
interface tdl_link_if;
  logic tx_req;
  logic tx_d4;
  logic [7:0] tx_byte;
  logic tx_bit;
  logic tx_last;
  logic rx_stb;
  logic rx_bit;
  logic rx_full;
  logic [7:0] rx_byte;
  modport tx_core (output tx_req, tx_d4, tx_byte, input tx_bit, tx_last);
  modport tx_unit (input tx_req, tx_d4, tx_byte, output tx_bit, tx_last);
  modport rx_core (output rx_stb, rx_bit, input rx_full, rx_byte);
  modport rx_unit (input rx_stb, rx_bit, output rx_full, rx_byte);
endinterface
`default_nettype wire

/* core/tdl_tx_ser.sv */
`default_nettype none
module tdl_tx_ser
  import tdl_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  tdl_link_if.tx_unit lk
);
  logic [7:0] sh;
  logic [2:0] idx;
  wire logic [2:0] last_idx = lk.tx_d4 ? LAST_BIT_D4 : LAST_BIT_ESF;
  // The byte is sampled at its first bit, so a late write resends the old one.
  wire logic [7:0] cur = (idx == 3'h0) ? lk.tx_byte : sh;
  wire logic at_last = (idx == last_idx);

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      sh <= REG_RESET;
      idx <= 3'h0;
      lk.tx_bit <= 1'b0;
      lk.tx_last <= 1'b0;
    end else begin
      lk.tx_last <= lk.tx_req && at_last;
      if (lk.tx_req) begin
        lk.tx_bit <= cur[0];
        sh <= {1'b0, cur[7:1]};
        idx <= at_last ? 3'h0 : idx + 3'h1;
      end
    end
  end

  AST_TX_FIRST_BIT_LSB: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    lk.tx_req && idx == 3'h0 |=> lk.tx_bit == $past(lk.tx_byte[0]))
    else $error("First serial bit is not the byte LSB.");
endmodule
`default_nettype wire

/* core/tdl_rx_col.sv */
`default_nettype none
module tdl_rx_col
  import tdl_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  tdl_link_if.rx_unit lk
);
  logic [7:0] sh;
  logic [2:0] cnt;
  // The first bit travels down to bit 0 after eight shifts.
  wire logic [7:0] next_sh = {lk.rx_bit, sh[7:1]};

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      sh <= REG_RESET;
      cnt <= 3'h0;
      lk.rx_full <= 1'b0;
      lk.rx_byte <= REG_RESET;
    end else begin
      lk.rx_full <= lk.rx_stb && cnt == 3'h7;
      if (lk.rx_stb) begin
        sh <= next_sh;
        cnt <= cnt + 3'h1;
        if (cnt == 3'h7) begin
          lk.rx_byte <= next_sh;
        end
      end
    end
  end
endmodule
`default_nettype wire

/* test/tdl_far_end.sv */
`default_nettype none
// ==========================================================
// Remote terminal: sends recovered link bits and pulls transmit overhead bits.
module tdl_far_end (
  input wire logic clk_in,
  input wire logic tx_bit_in,
  output logic rx_valid_out,
  output logic rx_bit_out,
  output logic rx_mf_out,
  output logic tx_req_out
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    rx_valid_out = 1'b0;
    rx_bit_out = 1'b0;
    rx_mf_out = 1'b0;
    tx_req_out = 1'b0;
  end

  // The data line is inverted outside its strobe so a stale level is never mistaken for data.
  task automatic send_byte(input logic [7:0] v);
    for (int i = 0; i < 8; i++) begin
      @(negedge clk_in);
      rx_valid_out = 1'b1;
      rx_bit_out = v[i];
      @(negedge clk_in);
      rx_valid_out = 1'b0;
      rx_bit_out = ~v[i];
      @(negedge clk_in);
    end
  endtask

  task automatic mf_pulse();
    @(negedge clk_in);
    rx_mf_out = 1'b1;
    @(negedge clk_in);
    rx_mf_out = 1'b0;
  endtask

  // The bit stands until the next request, so it is sampled one cycle late to be settled.
  task automatic pull_bits(output logic [7:0] v, input int n);
    v = 8'h00;
    for (int i = 0; i < n; i++) begin
      @(negedge clk_in);
      tx_req_out = 1'b1;
      @(negedge clk_in);
      tx_req_out = 1'b0;
      @(negedge clk_in);
      v[i] = tx_bit_in;
    end
  endtask
endmodule
`default_nettype wire

/* test/test_t1_data_link_boc_fdl.sv */
`default_nettype none
module test_t1_data_link_boc_fdl
  import tdl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic t1_mode_in = 1'b1;
  logic esf_mode_in = 1'b1;
  logic [8:0] reg_addr_in = 9'h000;
  logic reg_wr_in = 1'b0;
  logic [7:0] reg_wdata_in = 8'h00;
  logic [7:0] reg_rdata_out;
  logic rx_dl_valid_in, rx_dl_bit_in, rx_mf_in, tx_dl_req_in;
  logic tx_dl_bit_out, tx_dl_ins_out, interrupt_out_n;
  int err_total = 0;
  int check_count = 0;
  int cycles = 0;
  logic [7:0] v;
  localparam logic [8:0] ADDRS [10] = '{ADDR_RX_CODE_CONTROL, ADDR_RX_LINK_BYTE,
    ADDR_RX_CODE_VALUE, ADDR_RX_LATCHED_STATUS_SEVEN, ADDR_RX_INTERRUPT_MASK_SEVEN,
    ADDR_TX_LINK_BYTE, ADDR_TX_CONTROL_TWO, ADDR_TX_LATCHED_STATUS_TWO,
    ADDR_TX_INTERRUPT_MASK_TWO, 9'h1ff};

  always #12.5 clk_sys_in = ~clk_sys_in;

  tdl_top i_dut (
    .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .t1_mode_in(t1_mode_in),
    .esf_mode_in(esf_mode_in), .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in),
    .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
    .rx_dl_valid_in(rx_dl_valid_in), .rx_dl_bit_in(rx_dl_bit_in), .rx_mf_in(rx_mf_in),
    .tx_dl_req_in(tx_dl_req_in), .tx_dl_bit_out(tx_dl_bit_out),
    .tx_dl_ins_out(tx_dl_ins_out), .interrupt_out_n(interrupt_out_n));

  tdl_far_end i_far (
    .clk_in(clk_sys_in), .tx_bit_in(tx_dl_bit_out), .rx_valid_out(rx_dl_valid_in),
    .rx_bit_out(rx_dl_bit_in), .rx_mf_out(rx_mf_in), .tx_req_out(tx_dl_req_in));

  // ==========================================================
  // Shared tasks.
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(negedge clk_sys_in);
    reg_addr_in = a;
    reg_wr_in = 1'b1;
    reg_wdata_in = d;
    @(negedge clk_sys_in);
    reg_wr_in = 1'b0;
  endtask

  task automatic rd(input logic [8:0] a, output logic [7:0] d);
    @(negedge clk_sys_in);
    reg_addr_in = a;
    @(negedge clk_sys_in);
    d = reg_rdata_out;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys_in);
  endtask

  task automatic chk_int(input logic exp, input string what);
    chk({7'h00, interrupt_out_n}, {7'h00, exp}, what);
  endtask

  // A hang is cut short well above the fewer than one thousand cycles the sequence needs.
  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      report_and_stop();
    end
  end

  // ==========================================================
  // Main sequence.
  initial begin
    repeat (4) @(negedge clk_sys_in);
    rst_n_in = 1'b1;
    chk_int(1'b1, "idle interrupt");
    foreach (ADDRS[i]) begin
      rd(ADDRS[i], v);
      chk(v, REG_RESET, "reset or unmapped value");
    end
    $display("test reset done");

    wr(ADDR_RX_INTERRUPT_MASK_SEVEN, 8'h04);
    i_far.send_byte(8'ha5);
    cyc(4);
    chk_int(1'b0, "full interrupt");
    rd(ADDR_RX_LINK_BYTE, v);
    chk(v, 8'ha5, "rx byte");
    rd(ADDR_RX_LATCHED_STATUS_SEVEN, v);
    chk(v & 8'h04, 8'h04, "full flag");
    wr(ADDR_RX_LATCHED_STATUS_SEVEN, 8'h07);
    wr(ADDR_RX_INTERRUPT_MASK_SEVEN, 8'h00);
    i_far.send_byte(8'h7c);
    cyc(4);
    chk_int(1'b1, "masked full");
    rd(ADDR_RX_LINK_BYTE, v);
    chk(v, 8'h7c, "no destuffing");
    $display("test rx_byte done");

    wr(ADDR_RX_CODE_CONTROL, 8'h00);
    wr(ADDR_RX_INTERRUPT_MASK_SEVEN, 8'h01);
    wr(ADDR_RX_LATCHED_STATUS_SEVEN, 8'h07);
    i_far.send_byte(CODE_HEAD);
    i_far.send_byte({1'b0, 6'h2b, 1'b0});
    cyc(4);
    rd(ADDR_RX_LATCHED_STATUS_SEVEN, v);
    chk(v & 8'h01, 8'h01, "code detect");
    rd(ADDR_RX_CODE_VALUE, v);
    chk(v, 8'h2b, "code value");
    chk_int(1'b0, "detect interrupt");
    wr(ADDR_RX_LATCHED_STATUS_SEVEN, 8'h07);
    wr(ADDR_RX_INTERRUPT_MASK_SEVEN, 8'h00);
    cyc(4);
    rd(ADDR_RX_LATCHED_STATUS_SEVEN, v);
    chk(v & 8'h01, 8'h00, "detect stays clear");
    i_far.send_byte(CODE_HEAD);
    i_far.send_byte({1'b0, 6'h33, 1'b0});
    cyc(4);
    rd(ADDR_RX_LATCHED_STATUS_SEVEN, v);
    chk(v & 8'h01, 8'h01, "new code detect");
    rd(ADDR_RX_CODE_VALUE, v);
    chk(v, 8'h33, "new code value");
    repeat (6) i_far.send_byte(8'h00);
    cyc(4);
    rd(ADDR_RX_LATCHED_STATUS_SEVEN, v);
    chk(v & 8'h02, 8'h02, "code clear");
    $display("test code_detect done");

    wr(ADDR_RX_CODE_CONTROL, 8'h01);
    wr(ADDR_RX_LATCHED_STATUS_SEVEN, 8'h07);
    for (int r = 1; r <= 3; r++) begin
      i_far.send_byte(CODE_HEAD);
      i_far.send_byte({1'b0, 6'h15, 1'b0});
      cyc(4);
      rd(ADDR_RX_LATCHED_STATUS_SEVEN, v);
      chk(v & 8'h01, (r == 3) ? 8'h01 : 8'h00, "filter count");
    end
    rd(ADDR_RX_CODE_VALUE, v);
    chk(v, 8'h15, "filtered code");
    rd(ADDR_RX_LINK_BYTE, v);
    chk(v, 8'h2a, "latest byte kept");
    $display("test code_filter done");

    wr(ADDR_TX_CONTROL_TWO, 8'h80);
    wr(ADDR_TX_INTERRUPT_MASK_TWO, 8'h10);
    wr(ADDR_TX_LINK_BYTE, 8'h96);
    for (int p = 0; p < 3; p++) begin
      if (p == 2) wr(ADDR_TX_LINK_BYTE, 8'hff);
      i_far.pull_bits(v, 8);
      chk(v, (p == 2) ? 8'hff : 8'h96, "tx byte");
      chk({7'h00, tx_dl_ins_out}, 8'h01, "esf insert");
      cyc(4);
      rd(ADDR_TX_LATCHED_STATUS_TWO, v);
      chk(v & 8'h10, 8'h10, "empty flag");
      chk_int(1'b0, "empty interrupt");
      wr(ADDR_TX_LATCHED_STATUS_TWO, 8'h10);
    end
    cyc(4);
    chk_int(1'b1, "interrupt released");
    $display("test tx_esf done");

    esf_mode_in = 1'b0;
    cyc(2);
    chk({7'h00, tx_dl_ins_out}, 8'h00, "d4 source off");
    wr(ADDR_TX_CONTROL_TWO, 8'h00);
    wr(ADDR_TX_LINK_BYTE, 8'hdc);
    i_far.pull_bits(v, 6);
    chk(v, 8'h1c, "d4 fs pattern");
    chk({7'h00, tx_dl_ins_out}, 8'h01, "d4 insert");
    cyc(4);
    rd(ADDR_TX_LATCHED_STATUS_TWO, v);
    chk(v & 8'h10, 8'h10, "d4 empty");
    $display("test tx_d4 done");

    wr(ADDR_RX_LATCHED_STATUS_SEVEN, 8'h07);
    i_far.send_byte(CODE_HEAD);
    i_far.send_byte({1'b0, 6'h2b, 1'b0});
    cyc(4);
    rd(ADDR_RX_LINK_BYTE, v);
    chk(v, 8'h2a, "held until boundary");
    rd(ADDR_RX_LATCHED_STATUS_SEVEN, v);
    chk(v & 8'h01, 8'h00, "no detect in d4");
    i_far.mf_pulse();
    cyc(4);
    rd(ADDR_RX_LINK_BYTE, v);
    chk(v, 8'h56, "updated at boundary");
    $display("test rx_d4 done");
    report_and_stop();
  end
endmodule
`default_nettype wire
